// File: adr_pkg.sv
// constants and types shared by the result bus interface
// Function
// - internal clock is the oscillator input divided by four
// - every conversion cycle lasts exactly 1280 internal clocks
// - mode input high runs continuous conversions, low runs on-demand conversions
// - demand mode: one selected conversion strobe pulse starts exactly one conversion
// - chip enable low and chip select high are ANDed to qualify strobes
// - bus contents during the conversion strobe are ignored, nothing written
// - data bus driven only while selected and read strobe low
// - demand mode: byte select high gives bits 7-0, low gives bits 14-8
// - demand high byte top bit shows overrange or polarity per flag select
// - polarity 1 means positive; overrange 1 means beyond full scale
// - overrange reports cleared high bits and low byte 0 to 190
// - demand mode: bytes readable in any order until next conversion strobe
// - continuous mode ignores byte select and flag select
// - continuous order: high byte with polarity, low byte, high byte with overrange
// - continuous byte counter advances on each selected read strobe rising edge
// - continuous mode discards the result on the same internal clock that busy rises
// - busy rises before de-integrate, falls at cycle end with new data
// - busy stays high exactly 836 internal clocks
// - demand strobe ignored 1100 clocks after start; needs a falling edge
// - demand busy falls 1155 clocks after strobe; 125 more before next start
// - phases: zero 246, signal integrate 256, reference integrate 778 clocks
package adr_pkg;
   localparam logic [1:0] ADR_DIV_LAST = 2'h3;
   localparam logic [10:0] ADR_CYCLE_LEN = 11'h500;
   localparam logic [10:0] ADR_CYCLE_LAST = ADR_CYCLE_LEN - 11'h001;
   localparam logic [10:0] ADR_ZERO_LEN = 11'h0f6;
   localparam logic [10:0] ADR_INTEG_LEN = 11'h100;
   localparam logic [10:0] ADR_DEINT_LEN = 11'h30a;
   localparam logic [10:0] ADR_INTEG_START = ADR_ZERO_LEN;
   localparam logic [10:0] ADR_DEINT_START = ADR_ZERO_LEN + ADR_INTEG_LEN;
   localparam logic [10:0] ADR_BUSY_HIGH = 11'h344;
   localparam logic [10:0] ADR_BUSY_RISE = ADR_CYCLE_LEN - ADR_BUSY_HIGH;
   localparam logic [10:0] ADR_EOC_TO_STROBE = 11'h483;
   localparam logic [10:0] ADR_DEMAND_START = ADR_CYCLE_LEN - ADR_EOC_TO_STROBE;
   localparam logic [10:0] ADR_WR_BLANK = 11'h44c;
   localparam logic [10:0] ADR_WR_OPEN = ADR_DEMAND_START + ADR_WR_BLANK;
   localparam logic [7:0] ADR_OVR_LOW_MAX = 8'hbe;
   localparam logic [1:0] ADR_BYTE_POL = 2'h0;
   localparam logic [1:0] ADR_BYTE_LOW = 2'h1;
   localparam logic [1:0] ADR_BYTE_OVR = 2'h2;
   localparam logic [14:0] ADR_MAG_RESET = 15'h0000;
   localparam logic [7:0] ADR_BUS_IDLE = 8'h00;

   typedef enum logic [1:0] {
      ADR_ST_WAIT = 2'b01,
      ADR_ST_RUN = 2'b10
   } adr_state_t;
endpackage : adr_pkg

// File: adr_osc_div.sv
// oscillator input divider producing one internal-clock tick per four input periods
`timescale 1ns/100ps
`default_nettype none
module adr_osc_div (
   input wire logic sys_clk, // system clock
   input wire logic rst_sync_n, // synchronised reset, active low
   input wire logic osc_in, // oscillator or external clock level
   output logic tick // one-cycle pulse per internal clock
);
   typedef struct packed {
      logic osc_prev;
      logic [1:0] cnt;
      logic tick;
   } adr_div_t;

   adr_div_t s_r;
   adr_div_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.osc_prev = osc_in;
      s_nxt.tick = 1'b0;
      if (osc_in && !s_r.osc_prev) begin
         s_nxt.cnt = s_r.cnt + 2'h1;
         s_nxt.tick = (s_r.cnt == adr_pkg::ADR_DIV_LAST);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;
endmodule : adr_osc_div
`default_nettype wire

// File: adr_result_bus.sv
// conversion sequencer, result holding register and three-state result bus
`timescale 1ns/100ps
`default_nettype none
module adr_result_bus (
   input wire logic sys_clk, // system clock, 100 MHz
   input wire logic rst_n, // asynchronous reset, active low
   input wire logic clock_input_pin, // oscillator or external clock input
   input wire logic chip_en_n, // chip enable, active low
   input wire logic chip_sel, // chip select, active high
   input wire logic conv_strobe_n, // conversion strobe, active low
   input wire logic read_strobe_n, // read strobe, active low
   input wire logic byte_sel, // high picks low byte, low picks high byte
   input wire logic flag_select, // high puts overrange, low polarity on top bit
   input wire logic mode_select_in, // high continuous, low on demand
   input wire logic conv_positive, // comparator polarity at end of cycle
   input wire logic conv_overrange, // input beyond full scale
   input wire logic [14:0] conv_count, // de-integrate count from the counters
   output logic [6:0] lower_data_bits, // data bus bits 6..0
   output logic top_data_bit, // data bus bit 7
   output logic data_oe_n, // low while the bus is driven
   output logic busy, // end-of-conversion output
   output logic phase_zero, // zero integrator phase
   output logic phase_integ, // signal integrate phase
   output logic phase_deint // reference integrate phase
);
   typedef struct packed {
      adr_pkg::adr_state_t st;
      logic [10:0] cnt;
      logic busy;
      logic pend;
      logic wr_prev;
      logic rd_prev;
      logic [1:0] idx;
      logic pos;
      logic ovr;
      logic [14:0] mag;
      logic [7:0] dout;
      logic oe_n;
      logic ph_z;
      logic ph_i;
      logic ph_d;
   } adr_core_t;

   localparam adr_core_t ADR_CORE_RESET = '{
      st: adr_pkg::ADR_ST_WAIT,
      cnt: adr_pkg::ADR_DEMAND_START,
      busy: 1'b0,
      pend: 1'b0,
      wr_prev: 1'b1,
      rd_prev: 1'b1,
      idx: adr_pkg::ADR_BYTE_POL,
      pos: 1'b0,
      ovr: 1'b0,
      mag: adr_pkg::ADR_MAG_RESET,
      dout: adr_pkg::ADR_BUS_IDLE,
      oe_n: 1'b1,
      ph_z: 1'b1,
      ph_i: 1'b0,
      ph_d: 1'b0
   };

   logic rst_meta_r;
   logic rst_sync_r;
   logic tick;
   adr_core_t s_r;
   adr_core_t s_nxt;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   adr_osc_div u_div (
      .sys_clk(sys_clk),
      .rst_sync_n(rst_sync_r),
      .osc_in(clock_input_pin),
      .tick(tick)
   );

   logic selected;
   logic wr_fall;
   logic rd_rise;
   logic wr_open;
   logic [7:0] high_byte;
   logic [7:0] bus_byte;
   logic [7:0] ovr_low;

   always_comb begin
      selected = !chip_en_n && chip_sel;
      // data lines are never sampled on the strobe
      wr_fall = selected && !conv_strobe_n && s_r.wr_prev;
      rd_rise = selected && read_strobe_n && !s_r.rd_prev;
      // strobes during the first 1100 clocks after a start are dropped
      wr_open = (s_r.st == adr_pkg::ADR_ST_WAIT) || (s_r.cnt >= adr_pkg::ADR_WR_OPEN) ||
                (s_r.cnt < adr_pkg::ADR_DEMAND_START);
      ovr_low = (conv_count[7:0] > adr_pkg::ADR_OVR_LOW_MAX) ? adr_pkg::ADR_OVR_LOW_MAX :
                conv_count[7:0];
      high_byte = {1'b0, s_r.mag[14:8]};
      bus_byte = adr_pkg::ADR_BUS_IDLE;
      if (mode_select_in) begin
         case (s_r.idx)
            adr_pkg::ADR_BYTE_POL: bus_byte = {s_r.pos, high_byte[6:0]};
            adr_pkg::ADR_BYTE_LOW: bus_byte = s_r.mag[7:0];
            adr_pkg::ADR_BYTE_OVR: bus_byte = {s_r.ovr, high_byte[6:0]};
            default: bus_byte = adr_pkg::ADR_BUS_IDLE;
         endcase
      end else if (byte_sel) begin
         bus_byte = s_r.mag[7:0];
      end else begin
         bus_byte = {flag_select ? s_r.ovr : s_r.pos, high_byte[6:0]};
      end
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.wr_prev = conv_strobe_n;
      s_nxt.rd_prev = read_strobe_n;

      // bus answers one system clock after the strobes
      s_nxt.oe_n = !(selected && !read_strobe_n);
      s_nxt.dout = s_nxt.oe_n ? adr_pkg::ADR_BUS_IDLE : bus_byte;

      if (rd_rise && mode_select_in) begin
         s_nxt.idx = (s_r.idx == adr_pkg::ADR_BYTE_OVR) ? adr_pkg::ADR_BYTE_POL :
                     s_r.idx + 2'h1;
      end

      // a strobe in the same cycle as the consuming tick counts in run, but is dropped on a start from wait
      if (wr_fall && wr_open && !mode_select_in) begin
         s_nxt.pend = 1'b1;
      end

      if (tick) begin
         case (s_r.st)
            adr_pkg::ADR_ST_WAIT: begin
               if (mode_select_in || s_r.pend) begin
                  s_nxt.st = adr_pkg::ADR_ST_RUN;
                  // start tick holds the count, so 1155 ticks remain until busy falls
                  s_nxt.cnt = adr_pkg::ADR_DEMAND_START;
                  s_nxt.pend = wr_fall && wr_open && !mode_select_in && !s_r.pend;
               end
            end
            adr_pkg::ADR_ST_RUN: begin
               if (s_r.cnt == adr_pkg::ADR_CYCLE_LAST) begin
                  s_nxt.cnt = 11'h000;
                  s_nxt.busy = 1'b0;
                  s_nxt.pos = conv_positive;
                  s_nxt.ovr = conv_overrange;
                  s_nxt.mag = conv_overrange ? {7'h00, ovr_low} : conv_count;
                  s_nxt.idx = adr_pkg::ADR_BYTE_POL;
               end else if (s_r.cnt == adr_pkg::ADR_DEMAND_START - 11'h001 &&
                            !mode_select_in && !s_r.pend) begin
                  // park until the next accepted strobe
                  s_nxt.st = adr_pkg::ADR_ST_WAIT;
                  s_nxt.cnt = adr_pkg::ADR_DEMAND_START;
               end else begin
                  s_nxt.cnt = s_r.cnt + 11'h001;
                  if (s_r.cnt == adr_pkg::ADR_DEMAND_START - 11'h001 && !mode_select_in) begin
                     s_nxt.pend = wr_fall && wr_open;
                  end
                  if (s_nxt.cnt == adr_pkg::ADR_BUSY_RISE) begin
                     s_nxt.busy = 1'b1;
                     if (mode_select_in) begin
                        // unread continuous data is lost here
                        s_nxt.mag = adr_pkg::ADR_MAG_RESET;
                        s_nxt.pos = 1'b0;
                        s_nxt.ovr = 1'b0;
                        s_nxt.idx = adr_pkg::ADR_BYTE_POL;
                     end
                  end
               end
            end
            default: begin
               s_nxt.st = adr_pkg::ADR_ST_WAIT;
               s_nxt.cnt = adr_pkg::ADR_DEMAND_START;
            end
         endcase
      end

      s_nxt.ph_z = (s_nxt.st == adr_pkg::ADR_ST_WAIT) ||
                   (s_nxt.cnt < adr_pkg::ADR_INTEG_START);
      s_nxt.ph_i = (s_nxt.st == adr_pkg::ADR_ST_RUN) && !s_nxt.ph_z &&
                   (s_nxt.cnt < adr_pkg::ADR_DEINT_START);
      s_nxt.ph_d = (s_nxt.st == adr_pkg::ADR_ST_RUN) &&
                   (s_nxt.cnt >= adr_pkg::ADR_DEINT_START);
   end

   always_ff @(posedge sys_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         s_r <= ADR_CORE_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign lower_data_bits = s_r.dout[6:0];
   assign top_data_bit = s_r.dout[7];
   assign data_oe_n = s_r.oe_n;
   assign busy = s_r.busy;
   assign phase_zero = s_r.ph_z;
   assign phase_integ = s_r.ph_i;
   assign phase_deint = s_r.ph_d;
endmodule : adr_result_bus
`default_nettype wire

// File: adr_result_bus_chk.sv
// concurrent checks on the result bus interface ports
`timescale 1ns/100ps
`default_nettype none
module adr_result_bus_chk (
   input wire logic sys_clk, // clock
   input wire logic rst_n, // reset
   input wire logic clock_input_pin, // osc
   input wire logic chip_en_n, // enable
   input wire logic chip_sel, // select
   input wire logic read_strobe_n, // read
   input wire logic byte_sel, // byte
   input wire logic flag_select, // flag
   input wire logic mode_select_in, // mode
   input wire logic [6:0] lower_data_bits, // bus
   input wire logic top_data_bit, // bus top
   input wire logic data_oe_n, // bus enable
   input wire logic busy, // eoc
   input wire logic phase_zero, // zero
   input wire logic phase_integ, // integrate
   input wire logic phase_deint // deintegrate
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire logic sel;
   logic osc_q;
   logic [11:0] osc_cnt;
   assign sel = !chip_en_n && chip_sel;
   // osc rises seen while busy; four per internal clock
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_q <= 1'b0;
         osc_cnt <= 12'h000;
      end else begin
         osc_q <= clock_input_pin;
         osc_cnt <= !busy ? 12'h000 : osc_cnt + 12'(clock_input_pin && !osc_q);
      end
   end
   oe_on_a: assert property (sel && !read_strobe_n |=> !data_oe_n) else $error("bus not driven");
   oe_only_a: assert property (!data_oe_n |-> $past(sel && !read_strobe_n)) else $error("bus driven idle");
   bus_zero_a: assert property (data_oe_n |-> {top_data_bit, lower_data_bits} == 8'h00)
      else $error("idle bus not zero");
   ovr_clear_a: assert property (!data_oe_n && top_data_bit &&
      $past(!mode_select_in && !byte_sel && flag_select) |-> lower_data_bits == 7'h00) else $error("ovr high");
   busy_len_a: assert property ($fell(busy) |-> osc_cnt == 12'hd10) else $error("busy length");
   busy_zero_a: assert property (busy |-> !phase_zero) else $error("busy in zero phase");
   integ_order_a: assert property ($rose(phase_integ) |-> $past(phase_zero)) else $error("integ order");
   deint_order_a: assert property ($fell(phase_integ) |-> phase_deint) else $error("deint order");
endmodule : adr_result_bus_chk
bind adr_result_bus adr_result_bus_chk i_adr_result_bus_chk (.*);
`default_nettype wire

// File: adr_host.sv
// host processor model on the result bus
`timescale 1ns/100ps
`default_nettype none
module adr_host (
   input wire logic sys_clk, // clock
   input wire logic [6:0] lower_data_bits, // bus
   input wire logic top_data_bit, // bus top
   input wire logic data_oe_n, // bus enable
   output logic chip_en_n, // enable
   output logic chip_sel, // select
   output logic conv_strobe_n, // start
   output logic read_strobe_n, // read
   output logic byte_sel, // byte
   output logic flag_select // flag
);
   initial begin
      chip_en_n = 1'b1;
      chip_sel = 1'b0;
      conv_strobe_n = 1'b1;
      read_strobe_n = 1'b1;
      byte_sel = 1'b0;
      flag_select = 1'b0;
   end
   // one strobe pulse, no data on the bus
   task automatic start_conv(input logic ce_n);
      @(posedge sys_clk) #1;
      chip_en_n = ce_n;
      chip_sel = 1'b1;
      conv_strobe_n = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 conv_strobe_n = 1'b1;
      chip_en_n = 1'b0;
   endtask : start_conv
   // strobe returns high after each byte
   task automatic read_byte(input logic cs, bs, fs, output logic [7:0] d, output logic oe_n);
      @(posedge sys_clk) #1;
      chip_sel = cs;
      byte_sel = bs;
      flag_select = fs;
      read_strobe_n = 1'b0;
      @(posedge sys_clk) #1;
      d = {top_data_bit, lower_data_bits};
      oe_n = data_oe_n;
      read_strobe_n = 1'b1;
   endtask : read_byte
endmodule : adr_host
`default_nettype wire

// File: adr_result_bus_interface_test.sv
// self-checking bench for the result bus interface
`timescale 1ns/100ps
`default_nettype none
module adr_result_bus_interface_test;
   logic sys_clk, rst_n, clock_input_pin, mode_select_in, conv_positive, conv_overrange;
   logic [14:0] conv_count;
   logic [6:0] lower_data_bits;
   logic top_data_bit, data_oe_n, busy, phase_zero, phase_integ, phase_deint;
   logic chip_en_n, chip_sel, conv_strobe_n, read_strobe_n, byte_sel, flag_select;
   logic [7:0] rd_val;
   logic rd_oe_n;
   int error_cnt = 0;
   int checks_done = 0;
   adr_result_bus i_adr_result_bus (.*);
   adr_host i_adr_host (.*);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // internal clock every 16 sys_clk cycles
   initial begin
      clock_input_pin = 1'b0;
      forever #20 clock_input_pin = ~clock_input_pin;
   end
   task automatic report_and_stop();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rd(input logic cs, bs, fs, input logic [7:0] exp);
      i_adr_host.read_byte(cs, bs, fs, rd_val, rd_oe_n);
      check({7'h00, rd_oe_n}, {7'h00, !cs});
      check(rd_val, exp);
   endtask : rd
   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      while (busy !== lvl && n < 25000) begin
         @(posedge sys_clk) #1;
         n++;
      end
      if (busy !== lvl) begin
         error_cnt++;
         $display("MISMATCH at %0t: busy wait ran out", $time);
         report_and_stop();
      end
   endtask : wait_busy
   task automatic t_demand();
      time t0;
      conv_positive = 1'b1;
      conv_count = 15'h2a5c;
      i_adr_host.start_conv(1'b1);
      repeat (6000) @(posedge sys_clk);
      #1 check({7'h00, busy}, 8'h00);
      t0 = $time;
      i_adr_host.start_conv(1'b0);
      wait_busy(1'b1);
      wait_busy(1'b0);
      check(8'(($time - t0) / 10 >= 18480 && ($time - t0) / 10 <= 18520), 8'h01);
      conv_count = 15'h0000; // held result must not follow the counters
      rd(1'b0, 1'b1, 1'b0, 8'h00);
      rd(1'b1, 1'b1, 1'b0, 8'h5c);
      rd(1'b1, 1'b0, 1'b0, 8'haa);
      rd(1'b1, 1'b0, 1'b1, 8'h2a);
   endtask : t_demand
   task automatic t_ovr();
      conv_positive = 1'b0;
      conv_overrange = 1'b1;
      conv_count = 15'h00c8;
      i_adr_host.start_conv(1'b0);
      wait_busy(1'b1);
      wait_busy(1'b0);
      rd(1'b1, 1'b1, 1'b1, 8'hbe);
      rd(1'b1, 1'b0, 1'b1, 8'h80);
      rd(1'b1, 1'b0, 1'b0, 8'h00);
   endtask : t_ovr
   task automatic t_cont();
      time t1;
      mode_select_in = 1'b1;
      conv_positive = 1'b1;
      conv_overrange = 1'b0;
      conv_count = 15'h1234;
      wait_busy(1'b1);
      t1 = $time;
      wait_busy(1'b0);
      rd(1'b1, 1'b1, 1'b1, 8'h92);
      rd(1'b1, 1'b0, 1'b0, 8'h34);
      rd(1'b1, 1'b1, 1'b0, 8'h12);
      wait_busy(1'b1);
      check(8'($time - t1 == 204800), 8'h01);
      rd(1'b1, 1'b0, 1'b0, 8'h00);
   endtask : t_cont
   initial begin
      rst_n = 1'b0;
      mode_select_in = 1'b0;
      conv_positive = 1'b0;
      conv_overrange = 1'b0;
      conv_count = 15'h0000;
      repeat (5) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      t_demand();
      t_ovr();
      t_cont();
      report_and_stop();
   end
   initial begin
      #900000;
      error_cnt++;
      $display("MISMATCH at %0t: run timed out", $time);
      report_and_stop();
   end
endmodule : adr_result_bus_interface_test
`default_nettype wire
